// *** rtl/mbsram_host.sv ***
// Host controller driving the muxed-bus static RAM board
`timescale 1ns/1ns
// Rules of the board this block drives
// RULE1 - Board latches bus value as address on each strobe falling edge.
// RULE2 - Every read or write starts with exactly one strobe falling edge.
// RULE3 - Address then data share twelve lines; line zero carries the MSB.
// RULE4 - Read/write select high for read, low for write.
// RULE5 - Memory select is active low; board answers only while it is low.
// RULE6 - Board holds 4K or 2K twelve-bit words, base set by jumpers.
// RULE7 - 2K board may answer only octal addresses 2000 through 5777.
// RULE8 - Board drives read data or takes write data only while selected.
module mbsram_host #(
   parameter bit SMALL_2K = 1'b0
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   input  wire mbsram_pkg::mbsram_req_type    req,
   input  wire logic                          req_valid,
   output logic                               req_ready,
   output logic [mbsram_pkg::BUS_W-1:0]       rdata,
   output logic                               rdata_valid,
   output logic                               req_refused,
   output mbsram_pkg::mbsram_pins_type        pins,
   input  wire logic [mbsram_pkg::BUS_W-1:0]  bus_in
);
   import mbsram_pkg::*;

   typedef enum logic [6:0] {
      S_IDLE   = 7'b0000001,
      S_SETUP  = 7'b0000010,
      S_HOLD   = 7'b0000100,
      S_ACCESS = 7'b0001000,
      S_WHOLD  = 7'b0010000,
      S_DIS    = 7'b0100000,
      S_HIGH   = 7'b1000000
   } mbsram_state_type;

   mbsram_state_type state;
   logic [CNT_W-1:0] cnt;
   logic             write;
   logic [BUS_W-1:0] addr;
   logic [BUS_W-1:0] wdata;
   logic             in_window;
   logic             last;
   logic [BUS_W-1:0] addr_lines;
   logic [BUS_W-1:0] wdata_lines;
   logic [BUS_W-1:0] bus_word;

   // Line zero carries the most significant bit of each word
   for (genvar b = 0; b < BUS_W; b++) begin : g_line
      assign addr_lines[BUS_W-1-b]  = req.addr[b]; // RULE3
      assign wdata_lines[BUS_W-1-b] = wdata[b]; // RULE3
      assign bus_word[BUS_W-1-b]    = bus_in[b]; // RULE3
   end

   // Addresses outside the fitted board's window never start a cycle
   assign in_window = !SMALL_2K || // RULE6
                      (req.addr >= WIN2K_LO && req.addr <= WIN2K_HI); // RULE7
   assign last      = (cnt == CNT_W'(1));
   assign req_ready = (state == S_IDLE);

   // Phase sequence; each phase ends when the counter reaches one
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (req_valid && in_window) begin
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (last) begin
                  state <= S_HOLD; // RULE1 RULE2
               end
            end
            S_HOLD: begin
               if (last) begin
                  state <= S_ACCESS;
               end
            end
            S_ACCESS: begin
               if (last) begin
                  state <= write ? S_WHOLD : S_DIS;
               end
            end
            S_WHOLD, S_DIS: begin
               if (last) begin
                  state <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (last) begin
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Phase counter, reloaded with the next phase length as each one ends
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
      end else begin
         unique case (state)
            S_IDLE: begin
               cnt <= CNT_W'(SETUP_CYC);
            end
            S_SETUP: begin
               cnt <= last ? CNT_W'(HOLD_CYC) : cnt - 1'b1;
            end
            S_HOLD: begin
               cnt <= last ? CNT_W'(ACCESS_CYC - HOLD_CYC) : cnt - 1'b1;
            end
            S_ACCESS: begin
               if (!last) begin
                  cnt <= cnt - 1'b1;
               end else if (write) begin
                  cnt <= CNT_W'(WHOLD_CYC);
               end else begin
                  cnt <= CNT_W'(DIS_CYC);
               end
            end
            S_WHOLD, S_DIS: begin
               cnt <= last ? CNT_W'(HIGH_CYC) : cnt - 1'b1;
            end
            S_HIGH: begin
               cnt <= cnt - 1'b1;
            end
         endcase
      end
   end

   // Request capture
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         write <= 1'b0;
         addr  <= '0;
         wdata <= '0;
      end else if (state == S_IDLE && req_valid) begin
         write <= req.write;
         addr  <= req.addr;
         wdata <= req.wdata;
      end
   end

   // Pin drive; select is released before the strobe rises
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pins.strobe  <= 1'b1;
         pins.rw_sel  <= 1'b1;
         pins.sel_n   <= 1'b1;
         pins.bus_out <= '0;
         pins.bus_oe  <= 1'b0;
      end else begin
         unique case (state)
            S_IDLE: begin
               pins.strobe <= 1'b1;
               pins.sel_n  <= 1'b1;
               pins.bus_oe <= 1'b0;
               if (req_valid && in_window) begin
                  // Address goes out a full setup time before the strobe
                  pins.bus_out <= addr_lines; // RULE3
                  pins.bus_oe  <= 1'b1;
                  pins.rw_sel  <= !req.write; // RULE4
               end
            end
            S_SETUP: begin
               if (last) begin
                  pins.strobe <= 1'b0; // RULE2
                  pins.sel_n  <= 1'b0; // RULE5
               end
            end
            S_HOLD: begin
               if (last) begin
                  // Address hold met: turn the lines round for data
                  pins.bus_out <= wdata_lines; // RULE3
                  pins.bus_oe  <= write; // RULE8
               end
            end
            S_ACCESS: begin
               if (last) begin
                  pins.sel_n <= 1'b1;
               end
            end
            S_WHOLD, S_DIS: begin
               if (last) begin
                  pins.bus_oe <= 1'b0;
                  pins.strobe <= 1'b1;
               end
            end
            S_HIGH: begin
               pins.strobe <= 1'b1;
            end
         endcase
      end
   end

   // Read word taken on the last access cycle, while still selected
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata       <= '0;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= 1'b0;
         if (state == S_ACCESS && last && !write) begin
            rdata       <= bus_word; // RULE8 RULE3
            rdata_valid <= 1'b1;
         end
      end
   end

   // Out-of-window request is dropped with a one-cycle pulse
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         req_refused <= 1'b0;
      end else begin
         req_refused <= state == S_IDLE && req_valid && !in_window; // RULE7
      end
   end
endmodule

// *** rtl/mbsram_pkg.sv ***
// Package: constants and types for the muxed-bus static RAM host port
package mbsram_pkg;
   localparam int unsigned BUS_W          = 12;
   localparam int unsigned CLK_PERIOD_NS  = 4;
   // Timing figures of the board, in ns (slower variant)
   localparam int unsigned T_ADDR_SETUP_NS = 25;
   localparam int unsigned T_ADDR_HOLD_NS  = 165;
   localparam int unsigned T_STROBE_HI_NS  = 200;
   localparam int unsigned T_STROBE_LO_NS  = 575;
   localparam int unsigned T_ACCESS_NS     = 575;
   localparam int unsigned T_WDATA_HOLD_NS = 50;
   localparam int unsigned T_DISABLE_NS    = 150;
   // Cycle counts, rounded up
   localparam int unsigned SETUP_CYC =
      (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_CYC =
      (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HIGH_CYC =
      (T_STROBE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACCESS_CYC =
      (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WHOLD_CYC =
      (T_WDATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIS_CYC =
      (T_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 8;
   // Window of the 2K variant beside onboard memory, octal 2000 to 5777
   localparam logic [11:0] WIN2K_LO = 12'h400;
   localparam logic [11:0] WIN2K_HI = 12'hbff;

   typedef struct packed {
      logic             write;
      logic [BUS_W-1:0] addr;
      logic [BUS_W-1:0] wdata;
   } mbsram_req_type;

   typedef struct packed {
      logic             strobe;
      logic             rw_sel;
      logic             sel_n;
      logic [BUS_W-1:0] bus_out;
      logic             bus_oe;
   } mbsram_pins_type;
endpackage

// *** verification/mbsram_properties.sv ***
// Checker: port timing of the muxed-bus RAM host
`timescale 1ns/1ns
module mbsram_properties #(parameter bit SMALL_2K = 1'b0) (
   input wire logic                        sys_clk,
   input wire logic                        rstn,
   input wire mbsram_pkg::mbsram_req_type  req,
   input wire logic                        req_valid,
   input wire logic                        req_ready,
   input wire logic                        rdata_valid,
   input wire logic                        req_refused,
   input wire mbsram_pkg::mbsram_pins_type pins
);
   import mbsram_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic oow;
   logic take;
   assign oow  = SMALL_2K && (req.addr < WIN2K_LO || req.addr > WIN2K_HI);
   assign take = req_valid && req_ready;
   AST_TAKE_FALL: assert property (
      take && !oow |-> ##[1:12] $fell(pins.strobe))
      else $error("no strobe fall");
   AST_REFUSE: assert property (take && oow |-> ##[1:2] req_refused)
      else $error("no refusal");
   AST_ADDR_SET: assert property (
      $fell(pins.strobe) |-> pins.bus_oe && $stable(pins.bus_out) &&
      !pins.sel_n) else $error("address phase");
   AST_RW_HOLD: assert property (
      !pins.strobe |-> $stable(pins.rw_sel)) else $error("rw_sel moved");
   AST_DATA_PHASE: assert property ($fell(pins.strobe) |-> ##42
      pins.bus_oe == !pins.rw_sel) else $error("data phase");
   AST_BUSY: assert property (!pins.strobe |-> !req_ready)
      else $error("ready in access");
   AST_SEL_IN: assert property (!pins.sel_n |-> !pins.strobe)
      else $error("select outside access");
   AST_READ_DONE: assert property ($rose(pins.sel_n) && pins.rw_sel
      |-> ##[0:2] rdata_valid) else $error("no read answer");
   cover property ($rose(pins.sel_n) && pins.rw_sel);
   cover property ($rose(pins.sel_n) && !pins.rw_sel);
   cover property (req_refused);
endmodule

// *** verification/mbsram_board.sv ***
// Behavioural model of the static RAM board
`timescale 1ns/1ns
module mbsram_board (
   input wire mbsram_pkg::mbsram_pins_type  pins,
   output logic [mbsram_pkg::BUS_W-1:0]     bus_in
);
   import mbsram_pkg::*;
   logic [BUS_W-1:0] mem [4096];
   logic [BUS_W-1:0] addr;
   // Pin bit k is line k; line zero holds the most significant bit
   function automatic logic [BUS_W-1:0] to_value(logic [BUS_W-1:0] v);
      for (int i = 0; i < BUS_W; i++) to_value[i] = v[BUS_W-1-i];
   endfunction
   always @(negedge pins.strobe) addr = to_value(pins.bus_out);
   always @(posedge pins.sel_n) begin
      if (!pins.rw_sel) mem[addr] = to_value(pins.bus_out);
   end
   // Released bus shows the stored word on a selected in-window read, else the inverse of the host word
   assign bus_in = pins.bus_oe ? pins.bus_out :
      (!pins.sel_n && pins.rw_sel &&
       addr >= WIN2K_LO && addr <= WIN2K_HI) ? to_value(mem[addr]) :
      ~pins.bus_out;
endmodule

// *** verification/mbsram_host_tb.sv ***
// Bench: corner and random accesses through the RAM host port
`timescale 1ns/1ns
module mbsram_host_tb;
   import mbsram_pkg::*;
   logic             sys_clk, rstn, req_valid, req_ready;
   logic             rdata_valid, req_refused;
   mbsram_req_type   req;
   mbsram_pins_type  pins;
   logic [BUS_W-1:0] rdata, bus_in, a, exp [int];
   logic [BUS_W-1:0] cor [6] = '{12'h400, 12'hbff, 12'h3ff, 12'hc00,
                                 12'h000, 12'hfff};
   int               bad_count, checks;
   mbsram_host #(.SMALL_2K(1'b1)) dut_u (.sys_clk, .rstn, .req, .req_valid,
      .req_ready, .rdata, .rdata_valid, .req_refused, .pins, .bus_in);
   mbsram_board board_u (.pins, .bus_in);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   function automatic logic in_win(logic [11:0] x);
      return x >= 12'h400 && x <= 12'hbff;
   endfunction
   task automatic chk(logic ok, string m);
      checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic acc(logic wr, logic [11:0] x, logic [11:0] d);
      int n;
      logic rf = 1'b0;
      req <= '{wr, x, d};
      req_valid <= 1'b1;
      do @(negedge sys_clk); while (req_ready !== 1'b1);
      @(posedge sys_clk);
      req_valid <= 1'b0;
      if (!in_win(x)) begin
         repeat (3) begin
            @(negedge sys_clk);
            rf |= req_refused === 1'b1;
            chk(pins.strobe, "strobe fell");
         end
         chk(rf, "not refused");
      end else if (wr) exp[x] = d;
      else begin
         for (n = 0; n < 400 && rdata_valid !== 1'b1; n++) @(negedge sys_clk);
         chk(n < 400 && rdata === exp[x], "read data");
         chk(board_u.addr === x, "latched address");
      end
      @(posedge sys_clk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      void'($urandom(32'h8571));
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (cor[i]) acc(1'b1, cor[i], 12'ha5c ^ 12'(i));
      foreach (cor[i]) if (in_win(cor[i])) acc(1'b0, cor[i], 12'h0);
      $display("test corners done");
      repeat (12) begin
         a = 12'($urandom_range(12'hbff, 12'h400));
         acc(1'b1, a, 12'($urandom));
         acc(1'b0, a, 12'h0);
      end
      $display("test random done");
      req <= '{1'b0, 12'h400, 12'h0};
      req_valid <= 1'b1;
      // Past the idle gap, so reset lands inside this read's access
      repeat (150) @(negedge sys_clk);
      chk(!pins.strobe && !pins.sel_n, "no access in flight");
      @(posedge sys_clk);
      rstn <= 1'b0;
      req_valid <= 1'b0;
      @(negedge sys_clk);
      chk(pins.strobe && pins.sel_n && !pins.bus_oe, "reset pins");
      @(posedge sys_clk);
      rstn <= 1'b1;
      acc(1'b0, 12'h400, 12'h0);
      $display("test reset done");
      tally_and_finish;
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      bad_count++;
      tally_and_finish;
   end
endmodule
bind mbsram_host mbsram_properties #(.SMALL_2K(SMALL_2K)) chk_u (.sys_clk,
   .rstn, .req, .req_valid, .req_ready, .rdata_valid, .req_refused, .pins);
